// file: verilog/ddr_phy_pkg.sv
/*
 Shared constants, carriers and helpers for the DDR2 PHY option block.
 Assumes a 32-bit APB register bus and a separate memory (link) clock.
*/
`default_nettype none
package ddr_phy_pkg;
	// ==================================================
	// Widths and shapes
	localparam int DATA_BITS = 16;
	localparam int LANES = DATA_BITS / 8;
	localparam int WORD_BITS = 2 * DATA_BITS;
	localparam int FIFO_ABITS = (DATA_BITS == 64) ? 4 : (DATA_BITS == 32) ? 5 : 6;
	localparam int PTR_BITS = FIFO_ABITS + 1;
	localparam int NARROW_BITS = 32;
	localparam int NARROW_RAMS = WORD_BITS / NARROW_BITS;
	localparam int UPPER_LANES = 4;
	localparam int DELAY_BITS = 6;
	localparam int LANE_STRIDE = 8;
	localparam int SKEW_BITS = 14;
	localparam logic [SKEW_BITS-1:0] SKEW_MAX = 14'h270F;
	localparam int EMR_BITS = 14;
	localparam int EMR_RTT0 = 2;
	localparam int EMR_RTT1 = 6;
	localparam int EMR_DQS_SE = 10;

	// ==================================================
	// Calibration timing
	localparam int NUM_CALIBRATORS = 4;
	localparam int CAL_BITS = 8;
	localparam int CAL_TIME_NS = 1600;
	localparam int DDR_CLK_MHZ = 100;
	localparam logic [CAL_BITS-1:0] CAL_CYCLES = CAL_BITS'((CAL_TIME_NS * DDR_CLK_MHZ + 999) / 1000);

	// ==================================================
	// Register map
	localparam int ADDR_BITS = 8;
	localparam logic [ADDR_BITS-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_BITS-1:0] REG_LANE = 8'h04;
	localparam logic [ADDR_BITS-1:0] REG_SKEW = 8'h08;
	localparam logic [ADDR_BITS-1:0] REG_EMR = 8'h0C;
	localparam logic [ADDR_BITS-1:0] REG_STATUS = 8'h10;
	localparam logic [ADDR_BITS-1:0] REG_WDATA = 8'h14;
	localparam logic [ADDR_BITS-1:0] REG_RDATA = 8'h18;
	localparam int CTRL_OCT = 0;
	localparam int CTRL_ODT = 1;
	localparam int CTRL_GATE = 3;
	localparam int CTRL_DQS_SE = 4;
	localparam int CTRL_BANK8 = 5;
	localparam int CTRL_RDCAP = 6;
	localparam int CTRL_BANK = 8;
	localparam int STAT_CAL = 0;
	localparam int STAT_WFULL = 1;
	localparam int STAT_REMPTY = 2;

	// ==================================================
	// Types
	typedef enum logic [1:0] {ODT_OFF = 2'h0, ODT_75 = 2'h1, ODT_150 = 2'h2, ODT_50 = 2'h3} odt_t;
	typedef struct packed {
		logic [UPPER_LANES-1:0][DELAY_BITS-1:0] lane_delay;
		logic [SKEW_BITS-1:0] skew_ps;
		odt_t odt;
		logic oct_en;
		logic dqs_gate;
		logic dqs_single;
		logic eight_banks;
		logic rd_capture;
		logic [2:0] bank;
	} cfg_t;
	localparam cfg_t CFG_RST = '0;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_BITS-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_t;

	// ==================================================
	// Helpers
	function automatic logic [PTR_BITS-1:0] bin2gray(input logic [PTR_BITS-1:0] b);
		return b ^ (b >> 1);
	endfunction

	function automatic logic ptr_full(input logic [PTR_BITS-1:0] wg, input logic [PTR_BITS-1:0] rg);
		return wg == {~rg[PTR_BITS-1:PTR_BITS-2], rg[PTR_BITS-3:0]};
	endfunction

	function automatic logic [EMR_BITS-1:0] emr_value(input cfg_t c);
		logic [EMR_BITS-1:0] e;
		e = '0;
		e[EMR_RTT0] = c.odt[0];
		e[EMR_RTT1] = c.odt[1];
		e[EMR_DQS_SE] = c.dqs_single;
		return e;
	endfunction
endpackage
`default_nettype wire

// file: verilog/dual_clock_ram.sv
/*
 Two-port memory with its own clock on each port, registered read.
 Assumes the caller keeps reads and writes of one address apart in time.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_clock_ram #(
	parameter int ABITS = 6,
	parameter int DBITS = 32
) (
	// Write port
	input wire logic clk_w,
	input wire logic we,
	input wire logic [ABITS-1:0] waddr,
	input wire logic [DBITS-1:0] wdata,
	// Read port
	input wire logic clk_r,
	input wire logic [ABITS-1:0] raddr,
	output logic [DBITS-1:0] rdata
);
	logic [DBITS-1:0] mem [0:(1<<ABITS)-1];

	always_ff @(posedge clk_w)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk_r)
	begin
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// file: verilog/ddr2_phy_options.sv
/*
 DDR2 PHY option block: APB registers on clk_sys, memory-side logic on clk_ddr,
 dual-clock FIFOs between them. Assumes memory pins are timed to clk_ddr.
*/
// Local design decisions: the address map and the APB interface to the registers.
// Notes on behaviour
// - Upper byte lanes get own 0-63 delays
// - Termination code: off, 75, 150, 50 ohm
// - Read sampling skew 0 to 9999 ps
// - On-chip termination on when bit set
// - Strobes gated outside reads when enabled
// - No-sync option bypasses config and FIFO pointer crossing registers
// - Eight-bank mode widens bank address
// - Single-ended strobe flag lands in mode bit 10
// - Configurable count of delay calibrators, four
// - FIFOs use memories clocked per port
// - FIFO memory shapes follow data width
// - Memory data width 16, 32 or 64; DATA_BITS is 16, and a wider FIFO word would overrun the 32-bit APB data
`timescale 1ns/1ps
`default_nettype none
module ddr2_phy_options #(
	parameter bit NO_SYNC = 1'b0,
	parameter bit NO_REF_CLK = 1'b0,
	parameter int NUM_CALIB = ddr_phy_pkg::NUM_CALIBRATORS
) (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Register bus
	input wire ddr_phy_pkg::apb_req_t apb_i,
	output ddr_phy_pkg::apb_rsp_t apb_o,
	// Link clock
	input wire logic clk_ddr,
	// Memory data pins
	input wire logic [ddr_phy_pkg::DATA_BITS-1:0] dq_i,
	output logic [ddr_phy_pkg::DATA_BITS-1:0] dq_o,
	output logic dq_oe,
	input wire logic [ddr_phy_pkg::LANES-1:0] dqs_i,
	output logic [ddr_phy_pkg::LANES-1:0] dqs_gated_o,
	// Memory control and tuning
	output logic [2:0] bank_o,
	output logic [ddr_phy_pkg::EMR_BITS-1:0] emr_o,
	output logic odt_on_o,
	output logic oct_en_o,
	output logic [ddr_phy_pkg::UPPER_LANES-1:0][ddr_phy_pkg::DELAY_BITS-1:0] lane_delay_o,
	output logic [ddr_phy_pkg::SKEW_BITS-1:0] skew_ps_o,
	output logic cal_ready_o
);
	localparam int PB = ddr_phy_pkg::PTR_BITS;
	localparam int AB = ddr_phy_pkg::FIFO_ABITS;
	localparam int DB = ddr_phy_pkg::DATA_BITS;
	localparam int WB = ddr_phy_pkg::WORD_BITS;

	// ==================================================
	// State
	typedef struct packed {
		ddr_phy_pkg::cfg_t cfg;
		ddr_phy_pkg::apb_rsp_t rsp;
		logic [PB-1:0] wf_wptr;
		logic [PB-1:0] wf_wgray;
		logic [PB-1:0] rf_rptr;
		logic [PB-1:0] rf_rgray;
		logic [2:0][PB-1:0] wf_rsync;
		logic [2:0][PB-1:0] rf_wsync;
		logic [2:0] cal_sync;
		logic cal_ready;
		logic rd_pop;
	} sys_t;
	typedef struct packed {
		logic [2:0] cfg_sync_unused;
		ddr_phy_pkg::cfg_t cfg;
		logic [PB-1:0] wf_rptr;
		logic [PB-1:0] wf_rgray;
		logic [PB-1:0] rf_wptr;
		logic [PB-1:0] rf_wgray;
		logic [2:0][PB-1:0] wf_wsync;
		logic [2:0][PB-1:0] rf_rsync;
		logic wr_half;
		logic rd_half;
		logic [DB-1:0] rd_low;
		logic [DB-1:0] dq_out;
		logic dq_oe;
		logic [ddr_phy_pkg::LANES-1:0] dqs_gated;
		logic [2:0] bank;
		logic [ddr_phy_pkg::EMR_BITS-1:0] emr;
		logic odt_on;
		logic oct_en;
		logic [NUM_CALIB-1:0][ddr_phy_pkg::CAL_BITS-1:0] cal_cnt;
		logic cal_ready;
	} ddr_t;

	sys_t s_ff;
	sys_t nxt_s;
	ddr_t d_ff;
	ddr_t nxt_d;
	ddr_phy_pkg::cfg_t [2:0] cfg_sync_ff;
	logic [1:0] rst_sys_ff;
	logic [1:0] rst_ddr_ff;
	logic rst_sys_n;
	logic rst_ddr_n;
	logic [PB-1:0] wf_rs;
	logic [PB-1:0] rf_ws;
	logic [PB-1:0] wf_ws;
	logic [PB-1:0] rf_rs;
	logic wf_full;
	logic rf_empty;
	logic wf_empty;
	logic rf_full;
	logic done;
	logic stall;
	logic wf_we;
	logic rf_we;
	logic cal_all;
	logic [31:0] rd_word;
	logic [WB-1:0] wf_rdata;
	logic [WB-1:0] rf_rdata;
	logic [WB-1:0] rf_word;
	logic [ddr_phy_pkg::LANES-1:0] dqs_now;

	function automatic logic reg_ok(input logic [ddr_phy_pkg::ADDR_BITS-1:0] a, input logic w);
		return (a == ddr_phy_pkg::REG_CTRL) || (a == ddr_phy_pkg::REG_LANE) || (a == ddr_phy_pkg::REG_SKEW)
			|| (a == ddr_phy_pkg::REG_WDATA) || (!w && ((a == ddr_phy_pkg::REG_EMR)
			|| (a == ddr_phy_pkg::REG_STATUS) || (a == ddr_phy_pkg::REG_RDATA)));
	endfunction

	// ==================================================
	// Reset release, one synchroniser per domain
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			rst_sys_ff <= 2'h0;
		else
			rst_sys_ff <= {rst_sys_ff[0], 1'b1};
	end
	always_ff @(posedge clk_ddr or negedge arst_n)
	begin
		if (!arst_n)
			rst_ddr_ff <= 2'h0;
		else
			rst_ddr_ff <= {rst_ddr_ff[0], 1'b1};
	end
	assign rst_sys_n = rst_sys_ff[1];
	assign rst_ddr_n = rst_ddr_ff[1];

	// ==================================================
	// FIFO memories: one wide write path, narrow read-path slices
	dual_clock_ram #(.ABITS(AB), .DBITS(WB)) u_wr_ram (
		.clk_w(clk_sys),
		.we(wf_we),
		.waddr(s_ff.wf_wptr[AB-1:0]),
		.wdata(apb_i.pwdata[WB-1:0]),
		.clk_r(clk_ddr),
		.raddr(nxt_d.wf_rptr[AB-1:0]),
		.rdata(wf_rdata)
	);
	for (genvar g = 0; g < ddr_phy_pkg::NARROW_RAMS; g++)
	begin : g_rd_ram
		dual_clock_ram #(.ABITS(AB), .DBITS(ddr_phy_pkg::NARROW_BITS)) u_rd_ram (
			.clk_w(clk_ddr),
			.we(rf_we),
			.waddr(d_ff.rf_wptr[AB-1:0]),
			.wdata(rf_word[g*ddr_phy_pkg::NARROW_BITS +: ddr_phy_pkg::NARROW_BITS]),
			.clk_r(clk_sys),
			.raddr(nxt_s.rf_rptr[AB-1:0]),
			.rdata(rf_rdata[g*ddr_phy_pkg::NARROW_BITS +: ddr_phy_pkg::NARROW_BITS])
		);
	end

	// ==================================================
	// System side: APB slave, no wait states unless a write meets a full FIFO
	always_comb
	begin
		nxt_s = s_ff;
		wf_rs = NO_SYNC ? d_ff.wf_rgray : s_ff.wf_rsync[2];
		rf_ws = NO_SYNC ? d_ff.rf_wgray : s_ff.rf_wsync[2];
		wf_full = ddr_phy_pkg::ptr_full(s_ff.wf_wgray, wf_rs);
		rf_empty = s_ff.rf_rgray == rf_ws;
		done = apb_i.psel & apb_i.penable & s_ff.rsp.pready;
		// A write into a full FIFO waits in the access phase instead of dropping data
		stall = apb_i.pwrite & (apb_i.paddr == ddr_phy_pkg::REG_WDATA) & wf_full;
		wf_we = done & apb_i.pwrite & (apb_i.paddr == ddr_phy_pkg::REG_WDATA);
		rd_word = '0;
		case (apb_i.paddr)
			ddr_phy_pkg::REG_CTRL:
			begin
				rd_word[ddr_phy_pkg::CTRL_OCT] = s_ff.cfg.oct_en;
				rd_word[ddr_phy_pkg::CTRL_ODT +: 2] = s_ff.cfg.odt;
				rd_word[ddr_phy_pkg::CTRL_GATE] = s_ff.cfg.dqs_gate;
				rd_word[ddr_phy_pkg::CTRL_DQS_SE] = s_ff.cfg.dqs_single;
				rd_word[ddr_phy_pkg::CTRL_BANK8] = s_ff.cfg.eight_banks;
				rd_word[ddr_phy_pkg::CTRL_RDCAP] = s_ff.cfg.rd_capture;
				rd_word[ddr_phy_pkg::CTRL_BANK +: 3] = s_ff.cfg.bank;
			end
			ddr_phy_pkg::REG_LANE:
				for (int i = 0; i < ddr_phy_pkg::UPPER_LANES; i++)
					rd_word[i*ddr_phy_pkg::LANE_STRIDE +: ddr_phy_pkg::DELAY_BITS] = s_ff.cfg.lane_delay[i];
			ddr_phy_pkg::REG_SKEW:
				rd_word[ddr_phy_pkg::SKEW_BITS-1:0] = s_ff.cfg.skew_ps;
			ddr_phy_pkg::REG_EMR:
				rd_word[ddr_phy_pkg::EMR_BITS-1:0] = ddr_phy_pkg::emr_value(s_ff.cfg);
			ddr_phy_pkg::REG_STATUS:
			begin
				rd_word[ddr_phy_pkg::STAT_CAL] = s_ff.cal_ready;
				rd_word[ddr_phy_pkg::STAT_WFULL] = wf_full;
				rd_word[ddr_phy_pkg::STAT_REMPTY] = rf_empty;
			end
			ddr_phy_pkg::REG_RDATA:
				rd_word = rf_empty ? 32'h0000_0000 : rf_rdata[31:0];
			default:
				rd_word = '0;
		endcase
		nxt_s.rsp.pready = apb_i.psel & ~s_ff.rsp.pready & ~stall;
		if (nxt_s.rsp.pready)
		begin
			nxt_s.rsp.pslverr = ~reg_ok(apb_i.paddr, apb_i.pwrite);
			nxt_s.rsp.prdata = apb_i.pwrite ? 32'h0000_0000 : rd_word;
			// Pop decided with the returned data, so a word landing mid-transfer is not lost
			nxt_s.rd_pop = ~apb_i.pwrite & (apb_i.paddr == ddr_phy_pkg::REG_RDATA) & ~rf_empty;
		end
		if (done & apb_i.pwrite & ~s_ff.rsp.pslverr)
		begin
			case (apb_i.paddr)
				ddr_phy_pkg::REG_CTRL:
				begin
					nxt_s.cfg.oct_en = apb_i.pwdata[ddr_phy_pkg::CTRL_OCT];
					nxt_s.cfg.odt = ddr_phy_pkg::odt_t'(apb_i.pwdata[ddr_phy_pkg::CTRL_ODT +: 2]);
					nxt_s.cfg.dqs_gate = apb_i.pwdata[ddr_phy_pkg::CTRL_GATE];
					nxt_s.cfg.dqs_single = apb_i.pwdata[ddr_phy_pkg::CTRL_DQS_SE];
					nxt_s.cfg.eight_banks = apb_i.pwdata[ddr_phy_pkg::CTRL_BANK8];
					nxt_s.cfg.rd_capture = apb_i.pwdata[ddr_phy_pkg::CTRL_RDCAP];
					nxt_s.cfg.bank = apb_i.pwdata[ddr_phy_pkg::CTRL_BANK +: 3];
				end
				ddr_phy_pkg::REG_LANE:
					for (int i = 0; i < ddr_phy_pkg::UPPER_LANES; i++)
						nxt_s.cfg.lane_delay[i] = apb_i.pwdata[i*ddr_phy_pkg::LANE_STRIDE +: ddr_phy_pkg::DELAY_BITS];
				ddr_phy_pkg::REG_SKEW:
					// Out-of-range skews saturate at the top of the range
					nxt_s.cfg.skew_ps = ((|apb_i.pwdata[31:ddr_phy_pkg::SKEW_BITS])
						|| (apb_i.pwdata[ddr_phy_pkg::SKEW_BITS-1:0] > ddr_phy_pkg::SKEW_MAX))
						? ddr_phy_pkg::SKEW_MAX : apb_i.pwdata[ddr_phy_pkg::SKEW_BITS-1:0];
				ddr_phy_pkg::REG_WDATA:
				begin
					nxt_s.wf_wptr = s_ff.wf_wptr + 1'b1;
					nxt_s.wf_wgray = ddr_phy_pkg::bin2gray(nxt_s.wf_wptr);
				end
				default:
					nxt_s.cfg = s_ff.cfg;
			endcase
		end
		if (done & s_ff.rd_pop)
		begin
			nxt_s.rf_rptr = s_ff.rf_rptr + 1'b1;
			nxt_s.rf_rgray = ddr_phy_pkg::bin2gray(nxt_s.rf_rptr);
		end
		nxt_s.wf_rsync = {s_ff.wf_rsync[1:0], d_ff.wf_rgray};
		nxt_s.rf_wsync = {s_ff.rf_wsync[1:0], d_ff.rf_wgray};
		nxt_s.cal_sync = {s_ff.cal_sync[1:0], d_ff.cal_ready};
		if (s_ff.cal_sync[1] == s_ff.cal_sync[2])
			nxt_s.cal_ready = s_ff.cal_sync[2];
	end

	always_ff @(posedge clk_sys or negedge rst_sys_n)
	begin
		if (!rst_sys_n)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	// ==================================================
	// Link side: settings take effect once two stages agree
	always_comb
	begin
		nxt_d = d_ff;
		if (NO_SYNC)
			nxt_d.cfg = s_ff.cfg;
		else if (cfg_sync_ff[1] == cfg_sync_ff[2])
			nxt_d.cfg = cfg_sync_ff[2];
		wf_ws = NO_SYNC ? s_ff.wf_wgray : d_ff.wf_wsync[2];
		rf_rs = NO_SYNC ? s_ff.rf_rgray : d_ff.rf_rsync[2];
		wf_empty = d_ff.wf_rgray == wf_ws;
		rf_full = ddr_phy_pkg::ptr_full(d_ff.rf_wgray, rf_rs);
		nxt_d.bank = d_ff.cfg.eight_banks ? d_ff.cfg.bank : {1'b0, d_ff.cfg.bank[1:0]};
		nxt_d.emr = ddr_phy_pkg::emr_value(d_ff.cfg);
		nxt_d.odt_on = d_ff.cfg.odt != ddr_phy_pkg::ODT_OFF;
		nxt_d.oct_en = d_ff.cfg.oct_en;
		dqs_now = d_ff.cfg.dqs_gate ? (dqs_i & {ddr_phy_pkg::LANES{d_ff.cfg.rd_capture}}) : dqs_i;
		nxt_d.dqs_gated = dqs_now;
		// Read capture: two beats, low half first; a word that finds the FIFO full is lost
		rf_we = 1'b0;
		rf_word = {dq_i, d_ff.rd_low};
		if (d_ff.cfg.rd_capture & dqs_now[0])
		begin
			nxt_d.rd_half = ~d_ff.rd_half;
			if (!d_ff.rd_half)
				nxt_d.rd_low = dq_i;
			else if (!rf_full)
			begin
				rf_we = 1'b1;
				nxt_d.rf_wptr = d_ff.rf_wptr + 1'b1;
				nxt_d.rf_wgray = ddr_phy_pkg::bin2gray(nxt_d.rf_wptr);
			end
		end
		// Write drive: each FIFO word leaves as low half then high half
		if (!d_ff.wr_half)
		begin
			nxt_d.dq_oe = ~wf_empty;
			nxt_d.wr_half = ~wf_empty;
			nxt_d.dq_out = wf_rdata[DB-1:0];
		end
		else
		begin
			nxt_d.wr_half = 1'b0;
			nxt_d.dq_out = wf_rdata[WB-1:DB];
			nxt_d.wf_rptr = d_ff.wf_rptr + 1'b1;
			nxt_d.wf_rgray = ddr_phy_pkg::bin2gray(nxt_d.wf_rptr);
		end
		cal_all = 1'b1;
		for (int i = 0; i < NUM_CALIB; i++)
		begin
			if (!NO_REF_CLK && (d_ff.cal_cnt[i] != ddr_phy_pkg::CAL_CYCLES))
			begin
				nxt_d.cal_cnt[i] = d_ff.cal_cnt[i] + 1'b1;
				cal_all = 1'b0;
			end
		end
		nxt_d.cal_ready = cal_all;
		nxt_d.wf_wsync = {d_ff.wf_wsync[1:0], s_ff.wf_wgray};
		nxt_d.rf_rsync = {d_ff.rf_rsync[1:0], s_ff.rf_rgray};
	end

	always_ff @(posedge clk_ddr or negedge rst_ddr_n)
	begin
		if (!rst_ddr_n)
		begin
			d_ff <= '0;
			cfg_sync_ff <= '0;
		end
		else
		begin
			d_ff <= nxt_d;
			cfg_sync_ff <= {cfg_sync_ff[1:0], s_ff.cfg};
		end
	end

	// ==================================================
	// Outputs
	assign apb_o = s_ff.rsp;
	assign dq_o = d_ff.dq_out;
	assign dq_oe = d_ff.dq_oe;
	assign dqs_gated_o = d_ff.dqs_gated;
	assign bank_o = d_ff.bank;
	assign emr_o = d_ff.emr;
	assign odt_on_o = d_ff.odt_on;
	assign oct_en_o = d_ff.oct_en;
	assign lane_delay_o = d_ff.cfg.lane_delay;
	assign skew_ps_o = d_ff.cfg.skew_ps;
	assign cal_ready_o = d_ff.cal_ready;

	// ==================================================
	// Checks
	sequence low_beat;
		d_ff.dq_oe && d_ff.wr_half;
	endsequence
	sequence high_beat;
		d_ff.dq_oe && !d_ff.wr_half;
	endsequence
	bank_width_a: assert property (@(posedge clk_ddr) disable iff (!rst_ddr_n)
		!d_ff.cfg.eight_banks ##1 1'b1 |-> !bank_o[2]) else $error("bank bit 2 set in four-bank mode");
	emr_strobe_a: assert property (@(posedge clk_ddr) disable iff (!rst_ddr_n)
		##1 emr_o[ddr_phy_pkg::EMR_DQS_SE] == $past(d_ff.cfg.dqs_single)) else $error("mode bit 10 wrong");
	odt_code_a: assert property (@(posedge clk_ddr) disable iff (!rst_ddr_n)
		##1 {emr_o[6], emr_o[2], odt_on_o} == {$past(d_ff.cfg.odt), $past(d_ff.cfg.odt) != 2'h0})
		else $error("termination code mismatch");
	gate_bypass_a: assert property (@(posedge clk_ddr) disable iff (!rst_ddr_n)
		!d_ff.cfg.dqs_gate |=> dqs_gated_o == $past(dqs_i)) else $error("strobe gated while disabled");
	skew_range_a: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
		s_ff.cfg.skew_ps <= 14'h270F) else $error("skew beyond range");
	oct_follow_a: assert property (@(posedge clk_ddr) disable iff (!rst_ddr_n)
		$changed(d_ff.cfg.oct_en) |=> oct_en_o == d_ff.cfg.oct_en) else $error("termination enable lags");
	cfg_settle_a: assert property (@(posedge clk_ddr) disable iff (!rst_ddr_n)
		!NO_SYNC && $changed(d_ff.cfg) |-> d_ff.cfg == $past(cfg_sync_ff[2], 1) && $past(cfg_sync_ff[1] == cfg_sync_ff[2]))
		else $error("setting applied before settling");
	write_pair_a: assert property (@(posedge clk_ddr) disable iff (!rst_ddr_n)
		low_beat |=> high_beat) else $error("write word not sent as two beats");
	wfifo_stall_a: assert property (@(posedge clk_sys) disable iff (!rst_sys_n)
		apb_i.psel && stall |=> !apb_o.pready) else $error("write accepted into full FIFO");
endmodule
`default_nettype wire

// file: verification/ddr_mem_model.sv
/*
 Memory-side stand-in: replays queued read words on the strobes, logs written beats.
 Assumes the block drives and samples its pins on the same link clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ddr_mem_model (
	// Link side
	input wire logic clk_ddr,
	input wire logic [ddr_phy_pkg::DATA_BITS-1:0] dq_o,
	input wire logic dq_oe,
	output logic [ddr_phy_pkg::DATA_BITS-1:0] dq_i,
	output logic [ddr_phy_pkg::LANES-1:0] dqs_i
);
	// ==================================================
	// Queues filled and emptied by the bench
	logic [31:0] rdq[$];
	logic [15:0] beats[$];
	logic [1:0] hold_lvl = 2'h0;
	logic [31:0] w;
	logic ph = 1'b0;
	initial
	begin
		dq_i = 16'h5A5A;
		dqs_i = 2'h0;
	end
	// ==================================================
	// Two beats a word, low half first
	always @(posedge clk_ddr)
	begin
		if (dq_oe === 1'b1)
			beats.push_back(dq_o);
		if (ph)
		begin
			dq_i <= w[31:16];
			ph <= 1'b0;
		end
		else if (rdq.size() > 0)
		begin
			w = rdq.pop_front();
			dqs_i <= 2'h3;
			dq_i <= w[15:0];
			ph <= 1'b1;
		end
		else
		begin
			// Idle bus toggles so a stale beat never passes for data
			dqs_i <= hold_lvl;
			dq_i <= ~dq_i;
		end
	end
endmodule
`default_nettype wire

// file: verification/ddr2_phy_options_bench.sv
/*
 Self-checking bench for the DDR2 PHY option block over APB.
 Assumes the memory model sits on the link pins and clocks run free.
*/
`timescale 1ns/1ps
`default_nettype none
module ddr2_phy_options_bench;
	// ==================================================
	// Signals
	logic clk_sys = 1'b0;
	logic clk_ddr = 1'b0;
	logic arst_n = 1'b0;
	ddr_phy_pkg::apb_req_t apb_i = '0;
	ddr_phy_pkg::apb_rsp_t apb_o;
	logic [15:0] dq_i, dq_o;
	logic dq_oe, odt_on_o, oct_en_o, cal_ready_o;
	logic [1:0] dqs_i, dqs_gated_o;
	logic [2:0] bank_o;
	logic [13:0] emr_o, skew_ps_o;
	logic [3:0][5:0] lane_delay_o;
	int fails = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h00000062;
	logic [31:0] rd, v, e;
	logic err;
	logic [31:0] skews[6];
	logic [31:0] expq[$];

	always #12.5 clk_sys = ~clk_sys;
	always #80 clk_ddr = ~clk_ddr;

	// Unrelated clocks, so crossing registers stay
	ddr2_phy_options #(.NO_SYNC(1'b0), .NO_REF_CLK(1'b0), .NUM_CALIB(4)) i_ddr2_phy_options (
		.clk_sys(clk_sys), .arst_n(arst_n), .apb_i(apb_i), .apb_o(apb_o), .clk_ddr(clk_ddr),
		.dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_i(dqs_i), .dqs_gated_o(dqs_gated_o),
		.bank_o(bank_o), .emr_o(emr_o), .odt_on_o(odt_on_o), .oct_en_o(oct_en_o),
		.lane_delay_o(lane_delay_o), .skew_ps_o(skew_ps_o), .cal_ready_o(cal_ready_o));
	ddr_mem_model i_ddr_mem_model (.clk_ddr(clk_ddr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .dqs_i(dqs_i));

	// ==================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] ex);
		tests_run++;
		if (seen !== ex)
		begin
			$display("[ERR] %s expected %h seen %h", name, ex, seen);
			fails++;
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		apb_i.psel <= 1'b1;
		apb_i.penable <= 1'b0;
		apb_i.pwrite <= wr;
		apb_i.paddr <= a;
		apb_i.pwdata <= d;
		@(posedge clk_sys);
		apb_i.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (apb_o.pready !== 1'b1 && n < 50);
		if (apb_o.pready !== 1'b1)
			fails++;
		rd = apb_o.prdata;
		err = apb_o.pslverr;
		apb_i.psel <= 1'b0;
		apb_i.penable <= 1'b0;
	endtask

	// Write, read back, then let the value cross to the link side
	task automatic wrb(input logic [7:0] a, input logic [31:0] d, input logic [31:0] ex);
		apb(1'b1, a, d);
		apb(1'b0, a, 32'h0);
		chk("readback", rd, ex);
		repeat (6) @(posedge clk_ddr);
		@(negedge clk_ddr);
	endtask

	// ==================================================
	// Watchdog
	initial
	begin
		#500000;
		fails++;
		end_of_test();
	end

	// ==================================================
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk_ddr);
		@(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (10) @(posedge clk_sys);
		chk("cal_early", cal_ready_o, 1'b0);
		chk("lane_rst", lane_delay_o, 24'h0);
		chk("odt_rst", odt_on_o, 1'b0);
		chk("oct_rst", oct_en_o, 1'b0);
		apb(1'b0, ddr_phy_pkg::REG_SKEW, 32'h0);
		chk("skew_rst", rd, 32'h0);
		apb(1'b1, ddr_phy_pkg::REG_EMR, 32'hFFFFFFFF);
		chk("emr_ro", err, 1'b1);
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped", err, 1'b1);
		skews = '{32'h0, 32'h270F, 32'h2710, 32'h3FFF, rnd() & 32'h3FFF, rnd() & 32'h3FFF};
		foreach (skews[i])
		begin
			e = (skews[i] > 32'h270F) ? 32'h270F : skews[i];
			wrb(ddr_phy_pkg::REG_SKEW, skews[i], e);
			chk("skew_out", skew_ps_o, e);
		end
		for (int i = 0; i < 3; i++)
		begin
			v = (i == 0) ? 32'h3F3F3F3F : rnd() & 32'h3F3F3F3F;
			wrb(ddr_phy_pkg::REG_LANE, v, v);
			for (int k = 0; k < 4; k++)
				chk("lane_out", lane_delay_o[k], v[8*k+:6]);
		end
		for (int i = 0; i < 8; i++)
		begin
			v = rnd() & 32'h0000073F;
			v[2:1] = i[1:0];
			v[5] = i[2];
			wrb(ddr_phy_pkg::REG_CTRL, v, v);
			e = {18'h0, 3'h0, v[4], 3'h0, v[2], 3'h0, v[1], 2'h0};
			chk("odt_on", odt_on_o, v[2:1] != 2'h0);
			chk("oct_en", oct_en_o, v[0]);
			chk("emr_pin", emr_o, e);
			chk("bank", bank_o, v[10:8] & {v[5], 2'h3});
			apb(1'b0, ddr_phy_pkg::REG_EMR, 32'h0);
			chk("emr_reg", rd, e);
		end
		i_ddr_mem_model.hold_lvl = 2'h3;
		wrb(ddr_phy_pkg::REG_CTRL, 32'h8, 32'h8);
		chk("dqs_gated", dqs_gated_o, 2'h0);
		wrb(ddr_phy_pkg::REG_CTRL, 32'h0, 32'h0);
		chk("dqs_open", dqs_gated_o, 2'h3);
		i_ddr_mem_model.hold_lvl = 2'h0;
		wrb(ddr_phy_pkg::REG_CTRL, 32'h48, 32'h48);
		for (int i = 0; i < 2; i++)
		begin
			v = rnd();
			expq.push_back(v);
			i_ddr_mem_model.rdq.push_back(v);
		end
		repeat (8) @(posedge clk_ddr);
		repeat (2)
		begin
			apb(1'b0, ddr_phy_pkg::REG_RDATA, 32'h0);
			chk("rd_word", rd, expq.pop_front());
		end
		apb(1'b0, ddr_phy_pkg::REG_RDATA, 32'h0);
		chk("rd_empty", rd, 32'h0);
		wrb(ddr_phy_pkg::REG_CTRL, 32'h0, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			v = rnd();
			expq.push_back(v);
			apb(1'b1, ddr_phy_pkg::REG_WDATA, v);
		end
		repeat (20) @(posedge clk_ddr);
		chk("beats", i_ddr_mem_model.beats.size(), 32'd6);
		while (expq.size() > 0 && i_ddr_mem_model.beats.size() > 1)
		begin
			v = expq.pop_front();
			chk("beat_lo", i_ddr_mem_model.beats.pop_front(), v[15:0]);
			chk("beat_hi", i_ddr_mem_model.beats.pop_front(), v[31:16]);
		end
		for (int n = 0; n < 400 && cal_ready_o !== 1'b1; n++)
			@(posedge clk_ddr);
		chk("cal_ready", cal_ready_o, 1'b1);
		apb(1'b0, ddr_phy_pkg::REG_STATUS, 32'h0);
		chk("status", rd[2:0], 3'h5);
		end_of_test();
	end
endmodule
`default_nettype wire
